// ---- hdl/ahb_seq.sv ----
// handshake-mode two-byte output sequencer of a 12-bit plus sign converter
// assumes send, mode and run/hold pins asynchronous; result from same clock
// What this block does
// - the upper byte flag marks the high byte on the bus and a load strobe rises for external latches.
// - while handshake mode is active and send is high the next byte is strobed onto the bus.
// - while send is held low after a strobe the enabled byte stays actively driven.
// - the receiver raises send again once it took the byte and the sequence advances.
// - the high-order byte goes first and the low-order byte second.
// - once the low byte is taken and send rises the lower byte flag rises to end the transfer.
// - with mode held high completed conversions are sent automatically, but only results that complete between sequences are latched.
// - a rising edge on mode starts one sequence on demand; mode may then fall.
// - the run/hold input starts conversions.
// - the result spans 14 lines split over the two bytes.
`timescale 1ns/10ps
module ahb_seq #(
  parameter logic [15:0] CONV_CYC = ahb_pkg::CONV_CYC_DEF
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 send_in,
  input  wire logic                 mode_in,
  input  wire logic                 run_in,
  input  wire ahb_pkg::ahb_result_type result_in,
  output ahb_pkg::ahb_bus_type      bus_out,
  output logic                      conv_busy_out
);
  import ahb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HIGH  = 3'b001,
    ST_HWAIT = 3'b010,
    ST_LOW   = 3'b011,
    ST_LWAIT = 3'b100,
    ST_END   = 3'b101,
    ST_HREADY = 3'b110
  } ahb_state_type;

  logic send_s, mode_s, run_s;
  ahb_sync2 u_send (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pin_in(send_in),
                    .sync_out(send_s));
  ahb_sync2 u_mode (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pin_in(mode_in),
                    .sync_out(mode_s));
  ahb_sync2 u_run  (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pin_in(run_in),
                    .sync_out(run_s));

  ////////////////////////////////////////////////////////////////////////////
  // conversion timer
  logic [15:0]    conv_cnt, next_conv_cnt;
  logic           busy, next_busy;
  logic           conv_done, next_conv_done;
  logic [13:0]    held, next_held;
  logic           mode_d, next_mode_d;
  logic           pend, next_pend;
  ahb_state_type  state, next_state;
  ahb_bus_type    bus, next_bus;
  logic           mode_rise;

  assign mode_rise = mode_s & ~mode_d;

  always_comb begin
    next_conv_cnt  = conv_cnt;
    next_busy      = busy;
    next_conv_done = 1'b0;
    next_held      = held;
    if (!busy && run_s) begin
      next_busy     = 1'b1;
      next_conv_cnt = CONV_CYC;
    end else if (busy) begin
      if (conv_cnt == ONE16) begin
        next_busy      = 1'b0;
        next_conv_done = 1'b1;
        // latch only outside a sequence so bytes of one result stay coherent
        if (state == ST_IDLE)
          next_held = result_in;
      end
      next_conv_cnt = conv_cnt - ONE16;
    end
    if (!rst_b_in) begin
      next_conv_cnt  = 16'h0000;
      next_busy      = 1'b0;
      next_conv_done = 1'b0;
      next_held      = 14'h0000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    conv_cnt  <= next_conv_cnt;
    busy      <= next_busy;
    conv_done <= next_conv_done;
    held      <= next_held;
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte sequencer
  always_comb begin
    next_state  = state;
    next_mode_d = mode_s;
    next_pend   = pend;
    next_bus    = bus;
    next_bus.load_strobe = 1'b0;
    if (mode_rise || (mode_s && conv_done))
      next_pend = 1'b1;
    case (state)
      ST_IDLE: begin
        next_bus.data_oe_b       = 8'hFF;
        next_bus.upper_byte_flag = 1'b0;
        next_bus.lower_byte_flag = 1'b0;
        if (pend && !busy) begin
          next_pend  = 1'b0;
          next_state = ST_HIGH;
        end
      end
      ST_HIGH: if (send_s) begin
        next_bus.data            = {2'b00, held[HIGH_MSB:HIGH_LSB]};
        next_bus.data_oe_b       = 8'hC0;
        next_bus.upper_byte_flag = 1'b1;
        next_bus.load_strobe     = 1'b1;
        next_state               = ST_HWAIT;
      end
      // synced send still shows the pre-strobe level for two cycles, so wait
      // for the receiver to drop it before looking for its return
      ST_HWAIT: if (!send_s) begin
        next_state = ST_HREADY;
      end
      ST_HREADY: if (send_s) begin
        next_state = ST_LOW;
      end
      ST_LOW: begin
        next_bus.data            = held[LOW_W-1:0];
        next_bus.data_oe_b       = 8'h00;
        next_bus.upper_byte_flag = 1'b0;
        next_bus.load_strobe     = 1'b1;
        next_state               = ST_LWAIT;
      end
      ST_LWAIT: if (!send_s) begin
        next_state = ST_END;
      end
      ST_END: if (send_s) begin
        next_bus.lower_byte_flag = 1'b1;
        next_bus.data_oe_b       = 8'hFF;
        next_state               = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!rst_b_in) begin
      next_state  = ST_IDLE;
      next_mode_d = 1'b0;
      next_pend   = 1'b0;
      next_bus    = '{data: 8'h00, data_oe_b: 8'hFF, upper_byte_flag: 1'b0,
                      lower_byte_flag: 1'b0, load_strobe: 1'b0};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state  <= next_state;
    mode_d <= next_mode_d;
    pend   <= next_pend;
    bus    <= next_bus;
  end

  assign bus_out       = bus;
  assign conv_busy_out = busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_high_taken;
    state == ST_HIGH && send_s;
  endsequence

  chk_high_first: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_high_taken |=> bus.upper_byte_flag && bus.load_strobe)
    else $error("high byte not sent first");
  chk_drive_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state == ST_LWAIT && !send_s) |=> bus.data_oe_b == 8'h00)
    else $error("low byte released early");
  chk_end_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state == ST_END && send_s) |=> bus.lower_byte_flag && state == ST_IDLE)
    else $error("end flag missing");
  chk_run_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!busy && run_s) |=> busy)
    else $error("conversion not started");
  chk_demand_seq: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    mode_rise |=> pend || state != ST_IDLE)
    else $error("demand lost");
  chk_auto_seq: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (mode_s && conv_done) |=> pend || state != ST_IDLE)
    else $error("auto sequence lost");
  chk_advance_low: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state == ST_HREADY && send_s) |=> ##1 (bus.data_oe_b == 8'h00 && !bus.upper_byte_flag))
    else $error("no advance to low byte");
  chk_high_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state == ST_HWAIT && !send_s) |=> bus.upper_byte_flag && bus.data_oe_b == 8'hC0)
    else $error("high byte released early");
  chk_high_width: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    bus.upper_byte_flag |-> bus.data_oe_b == 8'hC0)
    else $error("high byte width wrong");
  chk_strobe_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    bus.load_strobe |-> bus.data_oe_b != 8'hFF)
    else $error("strobe without data");
endmodule

// ---- hdl/ahb_pkg.sv ----
// constants and carrier types for the handshake byte output sequencer
// assumes a single 25 MHz clock domain
package ahb_pkg;
  localparam int          RESULT_W     = 14;
  localparam int          LOW_W        = 8;
  localparam int          HIGH_W       = 6;
  localparam int          HIGH_LSB     = 8;
  localparam int          HIGH_MSB     = 13;
  localparam logic [15:0] CONV_CYC_DEF = 16'h0400;
  localparam logic [15:0] ONE16        = 16'h0001;

  typedef struct packed {
    logic       over_range;
    logic       polarity;
    logic [11:0] magnitude;
  } ahb_result_type;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe_b;
    logic       upper_byte_flag;
    logic       lower_byte_flag;
    logic       load_strobe;
  } ahb_bus_type;
endpackage

// ---- hdl/ahb_sync2.sv ----
// two-flop synchroniser for pin inputs
// assumes the pin is asynchronous to sys_clk_in
`timescale 1ns/10ps
module ahb_sync2 (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic pin_in,
  output logic      sync_out
);
  import ahb_pkg::*;
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = rst_b_in ? pin_in : 1'b0;
    next_sync = rst_b_in ? meta : 1'b0;
  end

  always_ff @(posedge sys_clk_in) begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end
endmodule

// ---- tb/ahb_rx_model.sv ----
// receiver model: takes each strobed byte, drops send, raises it later
// assumes bus outputs registered on the rising edge of sys_clk_in
`timescale 1ns/10ps
module ahb_rx_model (
  input  wire logic                 sys_clk_in,
  input  wire ahb_pkg::ahb_bus_type bus_in,
  input  wire logic [7:0]           slow_in,
  output logic                      send_out,
  output logic [15:0]               pair_out,
  output logic [1:0]                flags_out,
  output logic [7:0]                ends_out
);
  import ahb_pkg::*;
  logic [7:0] wait_cnt;
  initial begin
    send_out  = 1'b1;
    pair_out  = 16'h0000;
    flags_out = 2'h0;
    ends_out  = 8'h00;
    wait_cnt  = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // slow_in must be at least 1, else send never returns
  always @(negedge sys_clk_in) begin
    if (bus_in.load_strobe) begin
      pair_out  <= {pair_out[7:0], bus_in.data};
      flags_out <= {flags_out[0], bus_in.upper_byte_flag};
      send_out  <= 1'b0; // byte taken, busy reading it
      wait_cnt  <= slow_in;
    end else if (wait_cnt > 8'h01) begin
      wait_cnt <= wait_cnt - 8'h01;
    end else if (wait_cnt == 8'h01) begin
      send_out <= 1'b1; // read done, slow_in cycles after the strobe
      wait_cnt <= 8'h00;
    end
    if (bus_in.lower_byte_flag) ends_out <= ends_out + 8'h01;
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the handshake byte output sequencer
// assumes a short conversion (16 cycles) and the receiver model
`timescale 1ns/10ps
module testbench;
  import ahb_pkg::*;
  typedef struct packed {
    ahb_result_type res;
    logic [7:0]     slow;
    logic [15:0]    exp;
  } ahb_row_type;
  logic           sys_clk_in = 1'b0;
  logic           rst_b_in, mode_in, run_in, send_in, conv_busy_out;
  ahb_result_type result_in;
  ahb_bus_type    bus_out;
  logic [7:0]     slow, ends, e0;
  logic [15:0]    pair;
  logic [1:0]     flags;
  int             err_count = 0;
  int             total_checks = 0;
  ahb_row_type    rows [4] = '{{14'h2ABC, 8'h01, 16'h2ABC}, {14'h1123, 8'h05, 16'h1123},
                               {14'h0000, 8'h14, 16'h0000}, {14'h3FFF, 8'h03, 16'h3FFF}};
  always #20 sys_clk_in = ~sys_clk_in;
  ahb_seq #(.CONV_CYC(16'h0010)) i_ahb_seq (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .send_in(send_in), .mode_in(mode_in), .run_in(run_in), .result_in(result_in),
    .bus_out(bus_out), .conv_busy_out(conv_busy_out));
  ahb_rx_model i_ahb_rx_model (.sys_clk_in(sys_clk_in), .bus_in(bus_out), .slow_in(slow),
    .send_out(send_in), .pair_out(pair), .flags_out(flags), .ends_out(ends));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the end-of-transfer count to reach a target
  task automatic wait_ends(input logic [7:0] target);
    for (int i = 0; i < 600 && ends != target; i++) @(negedge sys_clk_in);
    check("end count", {8'h00, target}, {8'h00, ends});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    stop_test();
  end
  initial begin
    rst_b_in = 1'b0;
    mode_in = 1'b0;
    run_in = 1'b1;
    slow = 8'h02;
    result_in = 14'h0000;
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    @(negedge sys_clk_in);
    check("idle oe", 16'h00FF, {8'h00, bus_out.data_oe_b});
    check("idle flags", 16'h0000, {14'h0, bus_out.upper_byte_flag, bus_out.lower_byte_flag});
    // on-demand rows: short mode pulse, then mode back low
    foreach (rows[r]) begin
      slow = rows[r].slow;
      result_in = rows[r].res;
      e0 = ends;
      repeat (20) @(negedge sys_clk_in);
      mode_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      mode_in = 1'b0;
      wait_ends(e0 + 8'h01);
      check("byte pair", rows[r].exp, pair);
      check("byte flags", 16'h0002, {14'h0, flags});
      repeat (2) @(negedge sys_clk_in);
      check("released oe", 16'h00FF, {8'h00, bus_out.data_oe_b});
      repeat (40) @(negedge sys_clk_in);
      check("no auto", {8'h00, e0 + 8'h01}, {8'h00, ends});
    end
    // auto mode: result changes after the first transfer
    slow = 8'h02;
    result_in = 14'h1555;
    e0 = ends;
    mode_in = 1'b1;
    wait_ends(e0 + 8'h01);
    check("auto first", 16'h1555, pair);
    result_in = 14'h2A0F;
    wait_ends(e0 + 8'h03);
    check("auto later", 16'h2A0F, pair);
    mode_in = 1'b0;
    // run/hold: conversions stop while held
    run_in = 1'b0;
    repeat (40) @(negedge sys_clk_in);
    check("held busy", 16'h0000, {15'h0, conv_busy_out});
    run_in = 1'b1;
    for (int i = 0; i < 40 && conv_busy_out !== 1'b1; i++) @(negedge sys_clk_in);
    check("run busy", 16'h0001, {15'h0, conv_busy_out});
    stop_test();
  end
endmodule
